// ### src/intc_top.sv
// Interrupt controller with per-source routing to event transfer channels.
// Assumes the CPU core reports its running level and acknowledges vectors.
//
// Notes on behaviour
// - Service starts 5 to 12 clocks after request.
// - Each source routes to interrupt or channel.
// - Channel service steals one cycle, no vector.
// - Move byte or word, step one pointer.
// - Counter decrements per service unless continuous.
// - Counter at zero raises the source's interrupt.
// - Eight channels with own pointers and counters.
// - Per source request, enable and priority level.
// - Sixteen priority levels arbitrate pending requests.
// - Preempt only for strictly higher priority.
// - Each source branches to its own vector.
// - Fast inputs flag on rising, falling or both.
// - Trap instruction number selects the vector.
// - Software setting a request flag raises interrupt.
// - Fast inputs use traps 18 to 1B hex.
// - Hardware trap service blocks interrupts and transfers.
`timescale 1ns/1ns
`default_nettype none
module intc_top (
   // Clock and reset.
   input  wire logic                          clk_i,
   input  wire logic                          rst_n_i,
   // Request sources.
   input  wire logic [intc_pkg::N_EXT-1:0]    ext_pin_i,
   input  wire logic [2*intc_pkg::N_EXT-1:0]  ext_edge_sel_i,
   input  wire logic [intc_pkg::N_PERIPH-1:0] periph_req_i,
   // Source control write.
   input  wire logic                          ctl_wr_i,
   input  wire logic [intc_pkg::SRC_W-1:0]    ctl_idx_i,
   input  wire logic                          ctl_req_i,
   input  wire logic                          ctl_en_i,
   input  wire logic [intc_pkg::LVL_W-1:0]    ctl_lvl_i,
   input  wire logic                          ctl_route_i,
   input  wire logic [intc_pkg::CHAN_W-1:0]   ctl_chan_i,
   // Channel entry write.
   input  wire logic                          chan_wr_i,
   input  wire logic [intc_pkg::CHAN_W-1:0]   chan_idx_i,
   input  wire logic [intc_pkg::ENTRY_W-1:0]  chan_data_i,
   // CPU side.
   input  wire logic [intc_pkg::LVL_W-1:0]    cpu_prio_i,
   input  wire logic                          cpu_in_hw_trap_i,
   input  wire logic                          cpu_trap_i,
   input  wire logic [intc_pkg::TNUM_W-1:0]   cpu_trap_num_i,
   input  wire logic                          irq_ack_i,
   output logic                               irq_valid_o,
   output logic      [intc_pkg::VEC_W-1:0]    irq_vector_o,
   output logic      [intc_pkg::LVL_W-1:0]    irq_level_o,
   // Transfer cycle taken from the CPU.
   output logic                               xfer_valid_o,
   output logic      [intc_pkg::PTR_W-1:0]    xfer_src_o,
   output logic      [intc_pkg::PTR_W-1:0]    xfer_dst_o,
   output logic                               xfer_word_o,
   // Status.
   output logic      [intc_pkg::N_SRC-1:0]    req_flags_o
);
   import intc_pkg::*;

   // Whole controller state in one record.
   typedef struct packed {
      state_e                         st;
      logic [WAIT_W-1:0]              wait_cnt;
      logic [N_SRC-1:0]               req;
      logic [N_SRC-1:0]               en;
      logic [N_SRC-1:0][LVL_W-1:0]    lvl;
      logic [N_SRC-1:0]               route;
      logic [N_SRC-1:0][CHAN_W-1:0]   chan;
      logic [N_EXT-1:0]               ext_prev;
      logic [SRC_W-1:0]               win;
      logic                           is_trap;
      logic                           trap_pend;
      logic [TNUM_W-1:0]              trap_num;
      logic                           irq_valid;
      logic [VEC_W-1:0]               irq_vec;
      logic [LVL_W-1:0]               irq_lvl;
      logic                           xfer_valid;
      logic [PTR_W-1:0]               xsrc;
      logic [PTR_W-1:0]               xdst;
      logic                           xword;
   } state_s;

   state_s             s_q;        // Registered state.
   state_s             s_d;        // Next state.
   logic [N_EXT-1:0]   ext_hit;    // Selected edge seen this cycle.
   logic [N_SRC-1:0]   hw_set;     // Hardware request pulses.
   logic               any_elig;   // Some source may be served.
   logic [SRC_W-1:0]   pick;       // Arbitration winner.
   logic               wb_en;      // Channel entry write-back.
   chan_entry_s        wb_data;    // Updated channel entry.
   chan_entry_s        rd_data;    // Entry of the winner's channel.
   logic               mem_we;
   logic [CHAN_W-1:0]  mem_waddr;
   logic [ENTRY_W-1:0] mem_wdata;
   logic [ENTRY_W-1:0] mem_rdata;
   chan_entry_s        wr_entry;   // Write data seen as an entry.

   // A source may be served when flagged, enabled and above the CPU level.
   function automatic logic elig(input state_s s, input int i,
                                 input logic [LVL_W-1:0] cur);
      elig = s.req[i] && s.en[i] && (s.lvl[i] > cur);
   endfunction

   // Edge detection on the fast inputs, per-input edge choice.
   always_comb begin
      for (int i = 0; i < N_EXT; i++) begin
         ext_hit[i] =
            (ext_edge_sel_i[2*i+EDGE_RISE_BIT] && ext_pin_i[i]
                && !s_q.ext_prev[i]) ||
            (ext_edge_sel_i[2*i+EDGE_FALL_BIT] && !ext_pin_i[i]
                && s_q.ext_prev[i]);
      end
      hw_set = {periph_req_i, ext_hit};
   end

   // Highest level wins; on a tie the lower source number wins.
   always_comb begin
      any_elig = 1'b0;
      pick     = '0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (elig(s_q, i, cpu_prio_i) &&
             (!any_elig || s_q.lvl[i] >= s_q.lvl[pick])) begin
            any_elig = 1'b1;
            pick     = SRC_W'(i);
         end
      end
   end

   // Channel entries; read address follows the winner's channel.
   chan_mem u_chan_mem (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .wr_i    (mem_we),
      .waddr_i (mem_waddr),
      .wdata_i (mem_wdata),
      .raddr_i (s_q.chan[s_q.win]),
      .rdata_o (mem_rdata)
   );
   assign rd_data = chan_entry_s'(mem_rdata);
   assign wr_entry = chan_entry_s'(mem_wdata);

   // A finished transfer's write-back beats a software write that collides.
   always_comb begin
      mem_we    = wb_en || chan_wr_i;
      mem_waddr = wb_en ? s_q.chan[s_q.win] : chan_idx_i;
      mem_wdata = wb_en ? ENTRY_W'(wb_data) : chan_data_i;
   end

   // Next-state logic: sequencer first, then software, then hardware sets,
   // so that a hardware request in a clearing cycle is never lost.
   always_comb begin
      s_d            = s_q;
      s_d.xfer_valid = 1'b0;
      s_d.ext_prev   = ext_pin_i;
      wb_en          = 1'b0;
      wb_data        = rd_data;
      unique case (s_q.st)
         ST_IDLE: begin
            // No new service while a hardware trap is running.
            if (!cpu_in_hw_trap_i) begin
               if (s_q.trap_pend) begin
                  s_d.is_trap  = 1'b1;
                  s_d.wait_cnt = WAIT_CYCLES;
                  s_d.st       = ST_WAIT;
               end else if (any_elig) begin
                  s_d.is_trap  = 1'b0;
                  s_d.win      = pick;
                  s_d.wait_cnt = WAIT_CYCLES;
                  s_d.st       = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            s_d.wait_cnt = s_q.wait_cnt - 1'b1;
            if (s_q.wait_cnt == 1'b1) begin
               if (s_q.is_trap) begin
                  // Trap runs at the current CPU level.
                  s_d.irq_valid = 1'b1;
                  s_d.irq_vec   = vec_of(s_q.trap_num);
                  s_d.irq_lvl   = cpu_prio_i;
                  s_d.trap_pend = 1'b0;
                  s_d.st        = ST_IRQ;
               end else if (!elig(s_q, int'(s_q.win), cpu_prio_i) ||
                            cpu_in_hw_trap_i) begin
                  // Withdrawn or outranked meanwhile: arbitrate again.
                  s_d.st = ST_IDLE;
               end else if (s_q.route[s_q.win] &&
                            (rd_data.cont || rd_data.count != CNT_ZERO)) begin
                  // One stolen cycle, no vector.
                  s_d.xfer_valid = 1'b1;
                  s_d.xsrc       = rd_data.src;
                  s_d.xdst       = rd_data.dst;
                  s_d.xword      = rd_data.word;
                  wb_en          = 1'b1;
                  if (rd_data.inc_dst) begin
                     wb_data.dst = rd_data.dst +
                                   (rd_data.word ? PTR_TWO : PTR_ONE);
                  end else begin
                     wb_data.src = rd_data.src +
                                   (rd_data.word ? PTR_TWO : PTR_ONE);
                  end
                  if (!rd_data.cont) begin
                     wb_data.count = rd_data.count - CNT_ONE;
                  end
                  // Last transfer leaves the flag up for the interrupt.
                  if (rd_data.cont || rd_data.count != CNT_ONE) begin
                     s_d.req[s_q.win] = 1'b0;
                  end
                  s_d.st = ST_XFER;
               end else begin
                  // Plain interrupt, or a channel whose counter ran out.
                  s_d.irq_valid = 1'b1;
                  s_d.irq_vec   = vec_of(SRC_TRAP_NUM[s_q.win]);
                  s_d.irq_lvl   = s_q.lvl[s_q.win];
                  s_d.st        = ST_IRQ;
               end
            end
         end
         ST_IRQ: begin
            // Vector stands until the CPU takes it.
            if (irq_ack_i) begin
               s_d.irq_valid = 1'b0;
               if (!s_q.is_trap) begin
                  s_d.req[s_q.win] = 1'b0;
               end
               s_d.st = ST_IDLE;
            end
         end
         ST_XFER: begin
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
      // Software control write; a written request acts like hardware.
      if (ctl_wr_i) begin
         s_d.req[ctl_idx_i]   = ctl_req_i;
         s_d.en[ctl_idx_i]    = ctl_en_i;
         s_d.lvl[ctl_idx_i]   = ctl_lvl_i;
         s_d.route[ctl_idx_i] = ctl_route_i;
         s_d.chan[ctl_idx_i]  = ctl_chan_i;
      end
      // A trap instruction queues its number.
      if (cpu_trap_i) begin
         s_d.trap_pend = 1'b1;
         s_d.trap_num  = cpu_trap_num_i;
      end
      s_d.req = s_d.req | hw_set;
   end

   // State register.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q     <= '0;
         s_q.st  <= ST_IDLE;
         s_q.lvl <= {N_SRC{LVL_RESET}};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   assign irq_valid_o  = s_q.irq_valid;
   assign irq_vector_o = s_q.irq_vec;
   assign irq_level_o  = s_q.irq_lvl;
   assign xfer_valid_o = s_q.xfer_valid;
   assign xfer_src_o   = s_q.xsrc;
   assign xfer_dst_o   = s_q.xdst;
   assign xfer_word_o  = s_q.xword;
   assign req_flags_o  = s_q.req;

   // Checks.
   a_resp_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (s_q.st == ST_IDLE && s_d.st == ST_WAIT) |=>
      (s_q.st == ST_WAIT) [*3] ##1 (irq_valid_o || xfer_valid_o ||
      s_q.st == ST_IDLE)) else $error("response window broken");
   a_xfer_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      xfer_valid_o |=> !xfer_valid_o && !irq_valid_o)
      else $error("transfer held too long");
   a_xfer_no_vector: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      xfer_valid_o |-> !irq_valid_o && s_q.st == ST_XFER)
      else $error("transfer with vector");
   a_ptr_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wb_en |-> (wr_entry.src != rd_data.src) !=
      (wr_entry.dst != rd_data.dst))
      else $error("not exactly one pointer stepped");
   a_count_dec: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wb_en && !rd_data.cont |->
      wr_entry.count == rd_data.count - CNT_ONE)
      else $error("counter not decremented");
   a_level_higher: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(irq_valid_o) && !s_q.is_trap |->
      irq_level_o > $past(cpu_prio_i))
      else $error("served at or below running level");
   a_ext_vector: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(irq_valid_o) && !s_q.is_trap && s_q.win < N_EXT |->
      irq_vector_o == 16'h0060 + 16'(s_q.win) * 16'h0004)
      else $error("fast input vector wrong");
   a_trap_vector: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(irq_valid_o) && s_q.is_trap |->
      irq_vector_o == 16'(s_q.trap_num) * 16'h0004)
      else $error("trap vector wrong");
   a_edge_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ext_hit[0] |=> req_flags_o[0])
      else $error("edge did not set flag");
   a_sw_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ctl_wr_i && ctl_req_i |=> req_flags_o[$past(ctl_idx_i)])
      else $error("software request lost");
   a_trap_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.st == ST_IDLE && cpu_in_hw_trap_i |=> s_q.st == ST_IDLE)
      else $error("service started during trap");

endmodule
`default_nettype wire

// ### src/intc_pkg.sv
// Shared constants and types for the interrupt and event transfer controller.
// Assumes one 250 MHz clock domain; all sizes are fixed at build time.
package intc_pkg;

   // Number of request sources and of transfer channels.
   localparam int N_SRC     = 16;
   localparam int N_EXT     = 4;
   localparam int N_PERIPH  = N_SRC - N_EXT;
   localparam int N_CHAN    = 8;

   // Field widths.
   localparam int LVL_W     = 4;   // Sixteen priority levels.
   localparam int SRC_W     = 4;
   localparam int CHAN_W    = 3;
   localparam int PTR_W     = 16;
   localparam int CNT_W     = 8;
   localparam int TNUM_W    = 7;
   localparam int VEC_W     = 16;
   localparam int WAIT_W    = 4;

   // Edge select bits of a fast external input.
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;

   // Response window in CPU clocks, request cycle to service cycle.
   localparam int RESP_MIN_CLK  = 5;
   localparam int RESP_MAX_CLK  = 12;
   // Two clocks go to flag capture and winner selection.
   localparam int PIPE_CLK      = 2;
   localparam logic [WAIT_W-1:0] WAIT_CYCLES =
      WAIT_W'(RESP_MIN_CLK - PIPE_CLK);

   // A vector sits at the trap number times four.
   localparam int VEC_SHIFT = 2;

   // Trap numbers of the sources; the first four are the fast inputs.
   localparam logic [N_SRC-1:0][TNUM_W-1:0] SRC_TRAP_NUM = {
      7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2B, 7'h47, 7'h2A, 7'h29,
      7'h28, 7'h24, 7'h23, 7'h22, 7'h1B, 7'h1A, 7'h19, 7'h18};

   // Reset level of the sources; counter and pointer step constants.
   localparam logic [LVL_W-1:0] LVL_RESET = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
   localparam logic [PTR_W-1:0] PTR_ONE   = 16'h0001;
   localparam logic [PTR_W-1:0] PTR_TWO   = 16'h0002;

   // One channel entry: pointers, counter and mode bits.
   typedef struct packed {
      logic             cont;     // Continuous mode, counter frozen.
      logic             inc_dst;  // Step the destination, else the source.
      logic             word;     // Word transfer, else byte.
      logic [CNT_W-1:0] count;
      logic [PTR_W-1:0] dst;
      logic [PTR_W-1:0] src;
   } chan_entry_s;

   localparam int ENTRY_W = $bits(chan_entry_s);

   // Controller sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_IRQ  = 4'h4,
      ST_XFER = 4'h8
   } state_e;

   // Vector address of a trap number.
   function automatic logic [VEC_W-1:0] vec_of(input logic [TNUM_W-1:0] n);
      vec_of = VEC_W'({n, 2'b00});
   endfunction

endpackage

// ### src/chan_mem.sv
// Small store of the eight transfer channel entries.
// Assumes a single write port and a read port with registered data.
`timescale 1ns/1ns
`default_nettype none
module chan_mem (
   // Clock and reset.
   input  wire logic                            clk_i,
   input  wire logic                            rst_n_i,
   // Write port.
   input  wire logic                            wr_i,
   input  wire logic [intc_pkg::CHAN_W-1:0]     waddr_i,
   input  wire logic [intc_pkg::ENTRY_W-1:0]    wdata_i,
   // Read port, data one clock after the address.
   input  wire logic [intc_pkg::CHAN_W-1:0]     raddr_i,
   output logic      [intc_pkg::ENTRY_W-1:0]    rdata_o
);
   import intc_pkg::*;

   // Entry array; cleared at reset so counters start at zero.
   logic [N_CHAN-1:0][ENTRY_W-1:0] mem_q;

   // Write and registered read; a read of the word being written sees the
   // old value, which the controller never relies on.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_q   <= '0;
         rdata_o <= '0;
      end else begin
         if (wr_i) begin
            mem_q[waddr_i] <= wdata_i;
         end
         rdata_o <= mem_q[raddr_i];
      end
   end

endmodule
`default_nettype wire

// ### testbench/cpu_model.sv
// Behavioural CPU core that takes vector requests from the controller.
// Assumes the controller's clock and its active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Vector handshake.
   input  wire logic       irq_valid_i,
   input  wire logic [1:0] dly_i,
   output var  logic       irq_ack_o
);
   logic [1:0] wait_q;  // Cycles spent before the vector is taken.

   // Take a shown vector after dly_i cycles. The acknowledge drops at the
   // edge that samples it, because the request falls on that same edge and
   // a lingering acknowledge would swallow the next vector.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_ack_o <= 1'b0;
         wait_q    <= 2'h0;
      end else if (irq_ack_o) begin
         irq_ack_o <= 1'b0;
         wait_q    <= 2'h0;
      end else if (irq_valid_i) begin
         if (wait_q >= dly_i) begin
            irq_ack_o <= 1'b1;
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the interrupt and transfer controller.
// Assumes a CPU model that acknowledges vectors after a random delay.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import intc_pkg::*;
   // Stimulus, all driven by this bench.
   logic [N_EXT-1:0] ext_pin_i = '0;
   logic [2*N_EXT-1:0] ext_edge_sel_i = '0;
   logic [N_PERIPH-1:0] periph_req_i = '0;
   logic clk_i = 1'b0, rst_n_i = 1'b0, ctl_wr_i = 1'b0, ctl_req_i = 1'b0;
   logic ctl_en_i = 1'b0, ctl_route_i = 1'b0, chan_wr_i = 1'b0;
   logic cpu_in_hw_trap_i = 1'b0, cpu_trap_i = 1'b0;
   logic [SRC_W-1:0] ctl_idx_i = '0;
   logic [LVL_W-1:0] ctl_lvl_i = '0, cpu_prio_i = '0;
   logic [CHAN_W-1:0] ctl_chan_i = '0, chan_idx_i = '0;
   logic [ENTRY_W-1:0] chan_data_i = '0;
   logic [TNUM_W-1:0] cpu_trap_num_i = '0;
   logic [1:0] dly = 2'h0;
   // Observed outputs.
   logic irq_ack_i, irq_valid_o, xfer_valid_o, xfer_word_o;
   logic [VEC_W-1:0] irq_vector_o;
   logic [LVL_W-1:0] irq_level_o;
   logic [PTR_W-1:0] xfer_src_o, xfer_dst_o;
   logic [N_SRC-1:0] req_flags_o;
   // Scoreboard state; a note with t of -2 waits for its request edge.
   typedef struct {logic irq; logic [15:0] a; logic [15:0] b; logic w; int t;}
      note_s;
   note_s q[$];
   int errors = 0, n_tests = 0, cyc = 0;
   logic irq_seen = 1'b0;
   logic [31:0] seed = 32'h6BB0324A;

   intc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_pin_i(ext_pin_i),
      .ext_edge_sel_i(ext_edge_sel_i), .periph_req_i(periph_req_i),
      .ctl_wr_i(ctl_wr_i), .ctl_idx_i(ctl_idx_i), .ctl_req_i(ctl_req_i),
      .ctl_en_i(ctl_en_i), .ctl_lvl_i(ctl_lvl_i), .ctl_route_i(ctl_route_i),
      .ctl_chan_i(ctl_chan_i), .chan_wr_i(chan_wr_i), .chan_idx_i(chan_idx_i),
      .chan_data_i(chan_data_i), .cpu_prio_i(cpu_prio_i),
      .cpu_in_hw_trap_i(cpu_in_hw_trap_i), .cpu_trap_i(cpu_trap_i),
      .cpu_trap_num_i(cpu_trap_num_i), .irq_ack_i(irq_ack_i),
      .irq_valid_o(irq_valid_o), .irq_vector_o(irq_vector_o),
      .irq_level_o(irq_level_o), .xfer_valid_o(xfer_valid_o),
      .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o),
      .xfer_word_o(xfer_word_o), .req_flags_o(req_flags_o));
   cpu_model u_cpu (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .irq_valid_i(irq_valid_o), .dly_i(dly), .irq_ack_o(irq_ack_i));

   // Free-running 250 MHz clock.
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Vector of a source: fast inputs from 60 hex upward, others trap*4.
   function automatic logic [15:0] exp_vec(int k);
      return (k < 4) ? 16'(16'h0060 + 4 * k) : 16'({SRC_TRAP_NUM[k], 2'b00});
   endfunction

   function automatic void push(logic i, logic [15:0] a, b, logic w, int t);
      q.push_back('{i, a, b, w, t});
   endfunction

   // Give waiting notes the cycle of the edge that launches the request.
   function automatic void stamp();
      foreach (q[i]) if (q[i].t == -2) q[i].t = cyc;
   endfunction

   task automatic cmp(input logic [15:0] got, exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Compare one service against the oldest note.
   task automatic take(input logic i, input logic [15:0] a, b, input logic w);
      note_s n;
      if (q.size() == 0) begin
         cmp(16'h1, 16'h0, "unexpected service");
         return;
      end
      n = q.pop_front();
      cmp({15'h0, i}, {15'h0, n.irq}, "service kind");
      cmp(a, n.a, "vector or source");
      cmp(b, n.b, "level or destination");
      cmp({15'h0, w}, {15'h0, n.w}, "width");
      if (n.t >= 0)
         cmp(16'((cyc - n.t - 1) >= 5 && (cyc - n.t - 1) <= 12), 16'h1,
             "latency");
   endtask

   // Watch every transfer pulse and every rising vector request.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (xfer_valid_o === 1'b1) take(1'b0, xfer_src_o, xfer_dst_o,
                                      xfer_word_o);
      if (irq_valid_o === 1'b1 && irq_seen !== 1'b1)
         take(1'b1, irq_vector_o, {12'h0, irq_level_o}, 1'b0);
      irq_seen <= irq_valid_o;
   end

   task automatic ctl(input int k, input logic r, e, input logic [3:0] l,
                      input logic rt, input logic [2:0] c);
      @(posedge clk_i);
      stamp();
      ctl_wr_i <= 1'b1;
      ctl_idx_i <= 4'(k);
      ctl_req_i <= r;
      ctl_en_i <= e;
      ctl_lvl_i <= l;
      ctl_route_i <= rt;
      ctl_chan_i <= c;
      @(posedge clk_i);
      ctl_wr_i <= 1'b0;
   endtask

   task automatic preq(input int k);
      @(posedge clk_i);
      stamp();
      periph_req_i[k-4] <= 1'b1;
      @(posedge clk_i);
      periph_req_i <= '0;
   endtask

   task automatic chan(input int c, input chan_entry_s e);
      @(posedge clk_i);
      chan_wr_i <= 1'b1;
      chan_idx_i <= 3'(c);
      chan_data_i <= e;
      @(posedge clk_i);
      chan_wr_i <= 1'b0;
   endtask

   // Wait, bounded, until all noted services happened and the CPU is free.
   task automatic settle();
      int n;
      n = 0;
      dly <= 2'(rnd());
      do begin
         @(posedge clk_i);
         n++;
      end while ((q.size() != 0 || irq_valid_o !== 1'b0) && n < 300);
      if (n >= 300) cmp(16'h1, 16'h0, "service missing");
      repeat (3) @(posedge clk_i);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog: the whole sequence needs a few hundred cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      finish_test();
   end

   // Main sequence.
   initial begin
      chan_entry_s e;
      logic [31:0] r;
      int k;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      ext_edge_sel_i <= 8'hF9;  // Rise, fall, both, both.
      for (int i = 0; i < 4; i++) begin
         ctl(i, 1'b0, 1'b1, 4'(i + 1), 1'b0, 3'h0);
         if (i != 1) push(1'b1, exp_vec(i), 16'(i + 1), 1'b0, -2);
         @(posedge clk_i) stamp();
         ext_pin_i[i] <= 1'b1;
         settle();
         cmp({15'h0, req_flags_o[i]}, 16'h0, "flag after rise");
         if (i != 0) push(1'b1, exp_vec(i), 16'(i + 1), 1'b0, -2);
         @(posedge clk_i) stamp();
         ext_pin_i[i] <= 1'b0;
         settle();
         cmp({15'h0, req_flags_o[i]}, 16'h0, "flag after fall");
      end
      $display("test fast inputs done");
      for (int n = 0; n < 4; n++) begin
         r = rnd();
         k = 4 + int'(r[7:0]) % 12;
         ctl(k, 1'b0, 1'b1, r[11:8] | 4'h1, 1'b0, 3'h0);
         push(1'b1, exp_vec(k), 16'(r[11:8] | 4'h1), 1'b0, -2);
         preq(k);
         settle();
         cmp({15'h0, req_flags_o[k]}, 16'h0, "flag after service");
      end
      push(1'b1, exp_vec(13), 16'h7, 1'b0, -2);
      ctl(13, 1'b1, 1'b1, 4'h7, 1'b0, 3'h0);
      settle();
      for (int n = 0; n < 3; n++) begin
         r = rnd();
         push(1'b1, 16'({r[6:0], 2'b00}), 16'(r[11:8]), 1'b0, -2);
         cpu_prio_i <= r[11:8];
         @(posedge clk_i) stamp();
         cpu_trap_i <= 1'b1;
         cpu_trap_num_i <= r[6:0];
         @(posedge clk_i) cpu_trap_i <= 1'b0;
         settle();
      end
      $display("test vectors done");
      // Equal level and a disabled source hold off, then a hardware trap.
      cpu_prio_i <= 4'h5;
      ctl(6, 1'b0, 1'b1, 4'h5, 1'b0, 3'h0);
      ctl(7, 1'b0, 1'b0, 4'h9, 1'b0, 3'h0);
      preq(6);
      preq(7);
      repeat (15) @(posedge clk_i);
      cmp(16'(req_flags_o[7:6]), 16'h3, "held flags");
      cpu_prio_i <= 4'h4;
      cpu_in_hw_trap_i <= 1'b1;
      repeat (15) @(posedge clk_i);
      cmp(16'(req_flags_o[7:6]), 16'h3, "held in trap");
      push(1'b1, exp_vec(6), 16'h5, 1'b0, -1);
      cpu_in_hw_trap_i <= 1'b0;
      settle();
      cmp(16'(req_flags_o[7:6]), 16'h2, "flags after release");
      cpu_prio_i <= 4'h0;
      // Two requests in one cycle: the higher level goes first.
      ctl(8, 1'b0, 1'b1, 4'h3, 1'b0, 3'h0);
      ctl(9, 1'b0, 1'b1, 4'h9, 1'b0, 3'h0);
      push(1'b1, exp_vec(9), 16'h9, 1'b0, -2);
      push(1'b1, exp_vec(8), 16'h3, 1'b0, -1);
      @(posedge clk_i) stamp();
      periph_req_i <= 12'h030;
      @(posedge clk_i) periph_req_i <= '0;
      settle();
      $display("test priority done");
      // Word channel counts out, then the source's vector follows.
      r = rnd();
      e = '{cont: 1'b0, inc_dst: 1'b0, word: 1'b1, count: 8'h02,
            dst: r[31:16], src: r[15:0]};
      chan(7, e);
      ctl(10, 1'b0, 1'b1, 4'h4, 1'b1, 3'h7);
      push(1'b0, r[15:0], r[31:16], 1'b1, -2);
      preq(10);
      settle();
      push(1'b0, 16'(r[15:0] + 16'h2), r[31:16], 1'b1, -2);
      push(1'b1, exp_vec(10), 16'h4, 1'b0, -1);
      preq(10);
      settle();
      cmp({15'h0, req_flags_o[10]}, 16'h0, "flag after count out");
      // Continuous byte channel steps the destination and never counts out.
      r = rnd();
      e = '{cont: 1'b1, inc_dst: 1'b1, word: 1'b0, count: 8'h01,
            dst: r[31:16], src: r[15:0]};
      chan(0, e);
      ctl(11, 1'b0, 1'b1, 4'h2, 1'b1, 3'h0);
      for (int j = 0; j < 3; j++) begin
         push(1'b0, r[15:0], 16'(r[31:16] + j), 1'b0, -2);
         preq(11);
         settle();
      end
      $display("test channels done");
      finish_test();
   end
endmodule
`default_nettype wire
